// file: design/timer8_waveform_mode_control.sv
// Compare output and waveform generation control of an 8-bit timer.
// Assumes an 8-bit CPU data bus with single-cycle read and write strobes,
// a counter that reports match, top, bottom and max as one-cycle pulses,
// and a port block that supplies the pin direction and normal port data.
//
// Notes on behaviour
// - Phase A: 10 clear up, set down
// - Phase A 01: toggle only when mode-hi set
// - A equals top: ignore match, act bottom/top
// - B equals top: ignore match, act at top
// - Nonzero mode field overrides normal port function, except reserved codes and modes
// - Pin driven only when direction is output
// - Non-PWM B: off, toggle, clear, set
// - Fast B: 01 reserved, 10/11 non/inverting
// - Phase B: 01 reserved, 10 clear up
// - Three-bit mode field selects counting and top
// - Buffer update and overflow point follow mode
// - Force only acts in non-PWM modes
// - Force bit is a one-cycle match strobe
// - Force sets no flag, clears no counter
// - Force bits always read back zero
// - Control B at data 0x45, I/O 0x25
// - Control B resets zero, documented bit layout
// - Fast A: 10 clear on match, set bottom
// - Clock select picks stop, prescale or pin
// - Control A resets zero, documented layout, 0x44
`timescale 1ns/100ps
`include "timer8_wave_consts.svh"

module timer8_waveform_mode_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // CPU data bus
  input wire logic [7:0] busAddr,
  input wire logic ioSpace,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [7:0] busWData,
  output logic [7:0] busRData,
  // Counter events
  input wire logic compareMatchA,
  input wire logic compareMatchB,
  input wire logic countingUp,
  input wire logic atTop,
  input wire logic atBottom,
  input wire logic atMax,
  input wire logic compareAIsTop,
  input wire logic compareBIsTop,
  // Port block
  input wire logic dirOutA,
  input wire logic dirOutB,
  input wire logic portDataA,
  input wire logic portDataB,
  output logic pinOutA,
  output logic pinOeA,
  output logic pinOutB,
  output logic pinOeB,
  // Decoded configuration and events
  output timer8_wave_pkg::clk_src_t clockSelect,
  output timer8_wave_pkg::wave_mode_t waveGenMode,
  output logic topIsCompareA,
  output logic dualSlope,
  output logic counterClear,
  output logic compareFlagA,
  output logic compareFlagB,
  output logic compareUpdate,
  output logic overflowFlag,
  output logic waveOutA,
  output logic waveOutB,
  output logic overrideA,
  output logic overrideB
);

  // ========================================================================
  // Helper functions
  function automatic logic hits_reg(input logic [7:0] addr, input logic io, input logic [7:0] dataOfs);
    logic [7:0] ioOfs;
    ioOfs = dataOfs - `IO_SPACE_BIAS;
    hits_reg = io ? (addr == ioOfs) : (addr == dataOfs);
  endfunction

  function automatic timer8_wave_pkg::wave_class_t class_of(input timer8_wave_pkg::wave_mode_t mode);
    unique case (mode)
      timer8_wave_pkg::WAVE_NORMAL, timer8_wave_pkg::WAVE_CLR_MATCH: class_of = timer8_wave_pkg::CLASS_NONPWM;
      timer8_wave_pkg::WAVE_FAST_FF, timer8_wave_pkg::WAVE_FAST_CMPA: class_of = timer8_wave_pkg::CLASS_FAST;
      timer8_wave_pkg::WAVE_PHASE_FF, timer8_wave_pkg::WAVE_PHASE_CMPA: class_of = timer8_wave_pkg::CLASS_PHASE;
      timer8_wave_pkg::WAVE_RSVD_4, timer8_wave_pkg::WAVE_RSVD_6: class_of = timer8_wave_pkg::CLASS_NONE;
    endcase
  endfunction

  // ========================================================================
  // Register state
  logic [7:0] ctrlA_reg;
  logic [7:0] ctrlA_next;
  logic [7:0] ctrlB_reg;
  logic [7:0] ctrlB_next;
  logic forceA_reg;
  logic forceA_next;
  logic forceB_reg;
  logic forceB_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  logic selA;
  logic selB;
  logic [7:0] ctrlAView;
  logic [7:0] ctrlBView;
  timer8_wave_pkg::wave_class_t waveClass;
  timer8_wave_pkg::cmp_mode_t cmpOutModeA;
  timer8_wave_pkg::cmp_mode_t cmpOutModeB;
  logic waveGenModeHi;
  logic connectedA;
  logic connectedB;

  // ========================================================================
  // Address decode
  assign selA = hits_reg(busAddr, ioSpace, `CTRL_A_DATA_OFS);
  assign selB = hits_reg(busAddr, ioSpace, `CTRL_B_DATA_OFS);

  // Reserved bits are never stored, so they read as zero
  assign ctrlAView = {ctrlA_reg[`CMP_MODE_A_MSB:`CMP_MODE_B_LSB], 2'h0,
                      ctrlA_reg[`WAVE_LO_MSB:`WAVE_LO_LSB]};
  // Force bits are strobes and have no storage behind them
  assign ctrlBView = {4'h0, ctrlB_reg[`WAVE_HI_BIT], ctrlB_reg[`CLK_SEL_MSB:`CLK_SEL_LSB]};

  // ========================================================================
  // Register next values
  always_comb begin
    ctrlA_next = ctrlA_reg;
    ctrlB_next = ctrlB_reg;
    forceA_next = 1'b0;
    forceB_next = 1'b0;
    rdData_next = rdData_reg;
    if (busWrite && selA) begin
      ctrlA_next = busWData;
      ctrlA_next[3:2] = 2'h0;
    end
    if (busWrite && selB) begin
      ctrlB_next = busWData;
      ctrlB_next[`FORCE_A_BIT] = 1'b0;
      ctrlB_next[`FORCE_B_BIT] = 1'b0;
      ctrlB_next[5:4] = 2'h0;
      // Strobe lands one cycle later, after the new mode is in place
      forceA_next = busWData[`FORCE_A_BIT];
      forceB_next = busWData[`FORCE_B_BIT];
    end
    if (busRead) begin
      if (selA) begin
        rdData_next = ctrlAView;
      end else if (selB) begin
        rdData_next = ctrlBView;
      end else begin
        rdData_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlA_reg <= `CTRL_A_RESET;
      ctrlB_reg <= `CTRL_B_RESET;
      forceA_reg <= 1'b0;
      forceB_reg <= 1'b0;
      rdData_reg <= 8'h00;
    end else if (ce) begin
      ctrlA_reg <= ctrlA_next;
      ctrlB_reg <= ctrlB_next;
      forceA_reg <= forceA_next;
      forceB_reg <= forceB_next;
      rdData_reg <= rdData_next;
    end
  end

  assign busRData = rdData_reg;

  // ========================================================================
  // Field decode
  assign cmpOutModeA = timer8_wave_pkg::cmp_mode_t'(ctrlA_reg[`CMP_MODE_A_MSB:`CMP_MODE_A_LSB]);
  assign cmpOutModeB = timer8_wave_pkg::cmp_mode_t'(ctrlA_reg[`CMP_MODE_B_MSB:`CMP_MODE_B_LSB]);
  assign waveGenModeHi = ctrlB_reg[`WAVE_HI_BIT];
  assign waveGenMode = timer8_wave_pkg::wave_mode_t'({waveGenModeHi,
                       ctrlA_reg[`WAVE_LO_MSB:`WAVE_LO_LSB]});
  assign waveClass = class_of(waveGenMode);
  assign clockSelect = timer8_wave_pkg::clk_src_t'(ctrlB_reg[`CLK_SEL_MSB:`CLK_SEL_LSB]);

  // ========================================================================
  // Counting sequence and event points
  always_comb begin
    topIsCompareA = 1'b0;
    dualSlope = 1'b0;
    compareUpdate = 1'b0;
    overflowFlag = 1'b0;
    unique case (waveGenMode)
      timer8_wave_pkg::WAVE_NORMAL: begin
        compareUpdate = 1'b1;
        overflowFlag = atMax;
      end
      timer8_wave_pkg::WAVE_CLR_MATCH: begin
        topIsCompareA = 1'b1;
        compareUpdate = 1'b1;
        overflowFlag = atMax;
      end
      timer8_wave_pkg::WAVE_FAST_FF: begin
        compareUpdate = atBottom;
        overflowFlag = atMax;
      end
      timer8_wave_pkg::WAVE_FAST_CMPA: begin
        topIsCompareA = 1'b1;
        compareUpdate = atBottom;
        overflowFlag = atTop;
      end
      timer8_wave_pkg::WAVE_PHASE_FF: begin
        dualSlope = 1'b1;
        compareUpdate = atTop;
        overflowFlag = atBottom;
      end
      timer8_wave_pkg::WAVE_PHASE_CMPA: begin
        topIsCompareA = 1'b1;
        dualSlope = 1'b1;
        compareUpdate = atTop;
        overflowFlag = atBottom;
      end
      // Reserved modes run no sequence and raise nothing
      timer8_wave_pkg::WAVE_RSVD_4, timer8_wave_pkg::WAVE_RSVD_6: begin
        topIsCompareA = 1'b0;
      end
    endcase
  end

  // Only real matches reach the flags and the counter clear
  assign compareFlagA = compareMatchA;
  assign compareFlagB = compareMatchB;
  assign counterClear = compareMatchA && (waveGenMode == timer8_wave_pkg::WAVE_CLR_MATCH ||
                        waveGenMode == timer8_wave_pkg::WAVE_FAST_CMPA);

  // ========================================================================
  // Output units
  wave_output_unit #(
    .IS_CHANNEL_A(1'b1)
  ) unitA (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .cmpMode(cmpOutModeA),
    .waveClass(waveClass),
    .waveGenModeHi(waveGenModeHi),
    .compareMatch(compareMatchA),
    .forceStrobe(forceA_reg),
    .countingUp(countingUp),
    .atTop(atTop),
    .atBottom(atBottom),
    .compareIsTop(compareAIsTop),
    .waveOut(waveOutA),
    .connected(connectedA)
  );

  wave_output_unit #(
    .IS_CHANNEL_A(1'b0)
  ) unitB (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .cmpMode(cmpOutModeB),
    .waveClass(waveClass),
    .waveGenModeHi(waveGenModeHi),
    .compareMatch(compareMatchB),
    .forceStrobe(forceB_reg),
    .countingUp(countingUp),
    .atTop(atTop),
    .atBottom(atBottom),
    .compareIsTop(compareBIsTop),
    .waveOut(waveOutB),
    .connected(connectedB)
  );

  // ========================================================================
  // Pin multiplexing
  // A reserved combination leaves the normal port function in charge
  assign overrideA = connectedA;
  assign overrideB = connectedB;
  assign pinOutA = overrideA ? waveOutA : portDataA;
  assign pinOutB = overrideB ? waveOutB : portDataB;
  // Direction bit alone gates the driver, even when the waveform owns the pin
  assign pinOeA = dirOutA;
  assign pinOeB = dirOutB;

endmodule

// file: include/timer8_wave_consts.svh
// Offsets, field positions and reset values of the timer control registers.
// Assumes the including file needs them as plain text macros.
`ifndef TIMER8_WAVE_CONSTS_SVH
`define TIMER8_WAVE_CONSTS_SVH

// ==========================================================================
// Addressing
`define IO_SPACE_BIAS 8'h20
`define CTRL_A_DATA_OFS 8'h44
`define CTRL_B_DATA_OFS 8'h45

// ==========================================================================
// Reset values
`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h00

// ==========================================================================
// Control A fields
`define CMP_MODE_A_MSB 7
`define CMP_MODE_A_LSB 6
`define CMP_MODE_B_MSB 5
`define CMP_MODE_B_LSB 4
`define WAVE_LO_MSB 1
`define WAVE_LO_LSB 0

// ==========================================================================
// Control B fields
`define FORCE_A_BIT 7
`define FORCE_B_BIT 6
`define WAVE_HI_BIT 3
`define CLK_SEL_MSB 2
`define CLK_SEL_LSB 0

`endif

// file: include/timer8_wave_pkg.sv
// Types shared by the waveform control block and its output units.
// Assumes nothing beyond a SystemVerilog compiler.
package timer8_wave_pkg;

  // ========================================================================
  // Waveform generation modes
  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'b000,
    WAVE_PHASE_FF = 3'b001,
    WAVE_CLR_MATCH = 3'b010,
    WAVE_FAST_FF = 3'b011,
    WAVE_RSVD_4 = 3'b100,
    WAVE_PHASE_CMPA = 3'b101,
    WAVE_RSVD_6 = 3'b110,
    WAVE_FAST_CMPA = 3'b111
  } wave_mode_t;

  // ========================================================================
  // Behaviour classes of the output units
  typedef enum logic [1:0] {
    CLASS_NONPWM = 2'b00,
    CLASS_FAST = 2'b01,
    CLASS_PHASE = 2'b10,
    CLASS_NONE = 2'b11
  } wave_class_t;

  // ========================================================================
  // Compare output actions
  typedef enum logic [1:0] {
    CMP_DISCONNECT = 2'b00,
    CMP_TOGGLE = 2'b01,
    CMP_CLEAR = 2'b10,
    CMP_SET = 2'b11
  } cmp_mode_t;

  // ========================================================================
  // Timer clock sources
  typedef enum logic [2:0] {
    CLK_STOPPED = 3'b000,
    CLK_DIV1 = 3'b001,
    CLK_DIV8 = 3'b010,
    CLK_DIV64 = 3'b011,
    CLK_DIV256 = 3'b100,
    CLK_DIV1024 = 3'b101,
    CLK_EXT_FALL = 3'b110,
    CLK_EXT_RISE = 3'b111
  } clk_src_t;

endpackage

// file: design/wave_output_unit.sv
// One compare output flip-flop and its action decode.
// Assumes match, top and bottom inputs are one-cycle pulses from the counter.
`timescale 1ns/100ps

module wave_output_unit #(
  parameter bit IS_CHANNEL_A = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire timer8_wave_pkg::cmp_mode_t cmpMode,
  input wire timer8_wave_pkg::wave_class_t waveClass,
  input wire logic waveGenModeHi,
  input wire logic compareMatch,
  input wire logic forceStrobe,
  input wire logic countingUp,
  input wire logic atTop,
  input wire logic atBottom,
  input wire logic compareIsTop,
  output logic waveOut,
  output logic connected
);

  logic wave_reg;
  logic wave_next;
  logic specialPoint;

  // ========================================================================
  // Next output value
  always_comb begin
    wave_next = wave_reg;
    connected = 1'b0;
    // Channel A applies the top-value case at bottom in fast mode only
    specialPoint = (IS_CHANNEL_A && waveClass == timer8_wave_pkg::CLASS_FAST) ? atBottom : atTop;
    unique case (waveClass)
      timer8_wave_pkg::CLASS_NONPWM: begin
        connected = (cmpMode != timer8_wave_pkg::CMP_DISCONNECT);
        // Force acts only here, with the mode field as it stands now
        if (compareMatch || forceStrobe) begin
          unique case (cmpMode)
            timer8_wave_pkg::CMP_DISCONNECT: wave_next = wave_reg;
            timer8_wave_pkg::CMP_TOGGLE: wave_next = ~wave_reg;
            timer8_wave_pkg::CMP_CLEAR: wave_next = 1'b0;
            timer8_wave_pkg::CMP_SET: wave_next = 1'b1;
          endcase
        end
      end
      timer8_wave_pkg::CLASS_FAST, timer8_wave_pkg::CLASS_PHASE: begin
        if (cmpMode[1]) begin
          connected = 1'b1;
          if (compareIsTop) begin
            // Match ignored; output settles to the bottom-side level
            if (specialPoint) begin
              wave_next = ~cmpMode[0];
            end
          end else if (waveClass == timer8_wave_pkg::CLASS_FAST) begin
            if (compareMatch) begin
              wave_next = cmpMode[0];
            end else if (atBottom) begin
              wave_next = ~cmpMode[0];
            end
          end else if (compareMatch) begin
            wave_next = countingUp ? cmpMode[0] : ~cmpMode[0];
          end
        end else if (cmpMode[0] && IS_CHANNEL_A && waveGenModeHi) begin
          connected = 1'b1;
          if (compareMatch) begin
            wave_next = ~wave_reg;
          end
        end
        // Code 01 otherwise stays disconnected, reserved for channel B
      end
      timer8_wave_pkg::CLASS_NONE: begin
        wave_next = wave_reg;
      end
    endcase
  end

  // ========================================================================
  // Output register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wave_reg <= 1'b0;
    end else if (ce) begin
      wave_reg <= wave_next;
    end
  end

  assign waveOut = wave_reg;

endmodule

// file: test/timer8_waveform_mode_control_checker.sv
// Concurrent checks on the ports of the waveform control block.
// Assumes a bind from the bench; one clock domain, async active-high reset.
`timescale 1ns/100ps

module timer8_waveform_mode_control_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] busAddr,
  input wire logic ioSpace,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [7:0] busWData,
  input wire logic [7:0] busRData,
  input wire logic compareMatchA,
  input wire logic compareMatchB,
  input wire logic atTop,
  input wire logic atBottom,
  input wire logic atMax,
  input wire logic dirOutA,
  input wire logic dirOutB,
  input wire logic portDataA,
  input wire logic pinOutA,
  input wire logic pinOeA,
  input wire logic pinOeB,
  input wire timer8_wave_pkg::clk_src_t clockSelect,
  input wire timer8_wave_pkg::wave_mode_t waveGenMode,
  input wire logic topIsCompareA,
  input wire logic dualSlope,
  input wire logic counterClear,
  input wire logic compareFlagA,
  input wire logic compareFlagB,
  input wire logic compareUpdate,
  input wire logic overflowFlag,
  input wire logic waveOutA,
  input wire logic overrideA
);
  // ==========================================================================
  // Helpers
  logic [2:0] mode;
  logic hitB;
  assign mode = waveGenMode;
  assign hitB = ce && busAddr == (ioSpace ? 8'h25 : 8'h45);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Properties
  a_pin_drive: assert property (pinOeA == dirOutA && pinOeB == dirOutB)
    else $error("pin enable differs from direction bit");
  a_pin_owner: assert property (pinOutA == (overrideA ? waveOutA : portDataA))
    else $error("pin A value not taken from its owner");
  a_flag_pass: assert property (ce |-> compareFlagA == compareMatchA && compareFlagB == compareMatchB)
    else $error("compare flag not equal to counter match");
  a_clear_src: assert property (ce |-> counterClear == (compareMatchA && (mode == 3'h2 || mode == 3'h7)))
    else $error("counter clear from wrong source");
  a_ovf_point: assert property (ce |-> overflowFlag == (mode == 3'h7 ? atTop : (mode == 3'h1 || mode == 3'h5)
    ? atBottom : mode != 3'h4 && mode != 3'h6 && atMax))
    else $error("overflow flag at wrong point");
  a_update_point: assert property (ce |-> compareUpdate == ((mode == 3'h0 || mode == 3'h2) ||
    ((mode == 3'h1 || mode == 3'h5) && atTop) || ((mode == 3'h3 || mode == 3'h7) && atBottom)))
    else $error("compare update at wrong point");
  a_top_source: assert property (topIsCompareA == (mode == 3'h2 || mode == 3'h5 || mode == 3'h7) &&
    dualSlope == (mode == 3'h1 || mode == 3'h5))
    else $error("top source or slope decode wrong");
  a_force_read: assert property (busRead && hitB |=> busRData[7:6] == 2'h0)
    else $error("force bits read back nonzero");
  a_cfg_write: assert property (busWrite && hitB |=> {waveGenMode[2], clockSelect} == $past(busWData[3:0]))
    else $error("control B fields not taken from write");
  a_unmapped_read: assert property (ce && busRead && !ioSpace && busAddr == 8'h46 |=> busRData == 8'h00)
    else $error("unmapped read returned data");
endmodule

// file: test/timer8_waveform_mode_control_tb.sv
// Self-checking bench: cycle model of registers and compare outputs.
// Assumes the package, constants header and checker are compiled first.
`timescale 1ns/100ps

module timer8_waveform_mode_control_tb;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, ioSpace = 1'b0, busWrite = 1'b0, busRead = 1'b0;
  logic [7:0] busAddr = 8'h00, busWData = 8'h00, busRData;
  logic compareMatchA = 1'b0, compareMatchB = 1'b0, countingUp = 1'b0, atTop = 1'b0, atBottom = 1'b0;
  logic atMax = 1'b0, compareAIsTop = 1'b0, compareBIsTop = 1'b0;
  logic dirOutA = 1'b0, dirOutB = 1'b0, portDataA = 1'b0, portDataB = 1'b0;
  logic pinOutA, pinOeA, pinOutB, pinOeB, topIsCompareA, dualSlope, counterClear, compareFlagA;
  logic compareFlagB, compareUpdate, overflowFlag, waveOutA, waveOutB, overrideA, overrideB;
  timer8_wave_pkg::clk_src_t clockSelect;
  timer8_wave_pkg::wave_mode_t waveGenMode;
  integer seed = 32'h88FE06F7;
  int nMismatch = 0, numChecks = 0, i, j;
  logic ceRand = 1'b0, expA, expB, frcA, frcB;
  logic [7:0] regA, regB, rdExp;
  logic [2:0] m;
  logic [31:0] r;

  always #20 clk = ~clk;

  timer8_waveform_mode_control DUT (
    .clk(clk), .reset(reset), .ce(ce), .busAddr(busAddr), .ioSpace(ioSpace), .busWrite(busWrite),
    .busRead(busRead), .busWData(busWData), .busRData(busRData), .compareMatchA(compareMatchA),
    .compareMatchB(compareMatchB), .countingUp(countingUp), .atTop(atTop), .atBottom(atBottom),
    .atMax(atMax), .compareAIsTop(compareAIsTop), .compareBIsTop(compareBIsTop), .dirOutA(dirOutA),
    .dirOutB(dirOutB), .portDataA(portDataA), .portDataB(portDataB), .pinOutA(pinOutA), .pinOeA(pinOeA),
    .pinOutB(pinOutB), .pinOeB(pinOeB), .clockSelect(clockSelect), .waveGenMode(waveGenMode),
    .topIsCompareA(topIsCompareA), .dualSlope(dualSlope), .counterClear(counterClear),
    .compareFlagA(compareFlagA), .compareFlagB(compareFlagB), .compareUpdate(compareUpdate),
    .overflowFlag(overflowFlag), .waveOutA(waveOutA), .waveOutB(waveOutB), .overrideA(overrideA),
    .overrideB(overrideB)
  );

  // ==========================================================================
  // Random counter events and port inputs
  always @(posedge clk) begin
    r = $random(seed);
    ce <= !ceRand || r[31:29] != 3'h0;
    compareMatchA <= r[1:0] == 2'h0;
    compareMatchB <= r[3:2] == 2'h0;
    countingUp <= r[4];
    atTop <= r[6:5] == 2'h0;
    atBottom <= r[8:7] == 2'h0;
    atMax <= r[9] & r[10];
    compareAIsTop <= r[12:11] == 2'h0;
    compareBIsTop <= r[13] & r[14];
    {dirOutA, dirOutB, portDataA, portDataB} <= r[18:15];
  end

  // ==========================================================================
  // Reference model
  function automatic logic hit(input logic [7:0] a);
    return busAddr == (ioSpace ? a - 8'h20 : a);
  endfunction

  function automatic logic wv(input logic isA, cur, input logic [1:0] com, input logic frc, mt, tp);
    logic fast, ph;
    fast = m == 3'h3 || m == 3'h7;
    ph = m == 3'h1 || m == 3'h5;
    if (m == 3'h0 || m == 3'h2) begin
      if (!(mt || frc) || com == 2'h0) return cur;
      return com == 2'h1 ? ~cur : com[0];
    end
    if (!(fast || ph)) return cur;
    if (!com[1]) return isA && com[0] && m[2] && mt ? ~cur : cur;
    if (tp) return (isA && fast ? atBottom : atTop) ? ~com[0] : cur;
    if (fast) return mt ? com[0] : atBottom ? ~com[0] : cur;
    return mt ? (countingUp ? com[0] : ~com[0]) : cur;
  endfunction

  function automatic logic ov(input logic isA, input logic [1:0] com);
    logic [2:0] k;
    k = {regB[3], regA[1:0]};
    if (k == 3'h0 || k == 3'h2) return com != 2'h0;
    if (k == 3'h4 || k == 3'h6) return 1'b0;
    return com[1] || (isA && com == 2'h1 && k[2]);
  endfunction

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {regA, regB, rdExp} = 24'h000000;
      {expA, expB, frcA, frcB} = 4'h0;
    end else if (ce) begin
      m = {regB[3], regA[1:0]};
      expA = wv(1'b1, expA, regA[7:6], frcA, compareMatchA, compareAIsTop);
      expB = wv(1'b0, expB, regA[5:4], frcB, compareMatchB, compareBIsTop);
      frcA = busWrite && hit(8'h45) && busWData[7];
      frcB = busWrite && hit(8'h45) && busWData[6];
      if (busRead) rdExp = hit(8'h44) ? regA : hit(8'h45) ? regB : 8'h00;
      if (busWrite && hit(8'h44)) regA = busWData & 8'hF3;
      if (busWrite && hit(8'h45)) regB = busWData & 8'h0F;
    end
  end

  // ==========================================================================
  // Comparison and verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(negedge clk) begin
    if (!reset) begin
      check(16'({waveOutA, waveOutB}), 16'({expA, expB}));
      check(16'({overrideA, overrideB}), 16'({ov(1'b1, regA[7:6]), ov(1'b0, regA[5:4])}));
      check(16'({pinOutA, pinOeA}), 16'({ov(1'b1, regA[7:6]) ? expA : portDataA, dirOutA}));
      check(16'({pinOutB, pinOeB}), 16'({ov(1'b0, regA[5:4]) ? expB : portDataB, dirOutB}));
      check(16'(busRData), 16'(rdExp));
      check(16'({waveGenMode, clockSelect}), 16'({regB[3], regA[1:0], regB[2:0]}));
    end
  end

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Register bus: request held one cycle, taken at the next edge
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic io, input logic [7:0] d);
    busWrite <= wr;
    busRead <= !wr;
    busAddr <= io ? ofs - 8'h20 : ofs;
    ioSpace <= io;
    busWData <= d;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    busWrite <= 1'b0;
    busRead <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  initial begin
    #(40 * 12000);
    nMismatch++;
    giveVerdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h44, 1'b0, 8'h00);
    bus(1'b0, 8'h45, 1'b1, 8'h00);
    bus(1'b0, 8'h46, 1'b0, 8'h00);
    // Data-space offset seen in I/O space must not hit
    bus(1'b0, 8'h65, 1'b1, 8'h00);
    for (i = 0; i < 128; i++) begin
      bus(1'b1, 8'h44, i[3], {i[6:3], 2'h3, i[1:0]});
      bus(1'b1, 8'h45, i[4], {4'h3, i[2], i[5:3]});
      // Force strobes only while a non-PWM mode is set
      if (i[2:0] == 0 || i[2:0] == 2) bus(1'b1, 8'h45, !i[4], {4'hF, 1'b0, i[5:3]});
      bus(1'b0, 8'h44, i[5], 8'h00);
      bus(1'b0, 8'h45, i[6], 8'h00);
      idle(24);
    end
    ceRand <= 1'b1;
    for (j = 0; j < 200; j++) begin
      bus(1'b1, 8'h44, j[0], 8'($random(seed)));
      bus(1'b1, 8'h45, j[1], 8'($random(seed)) & 8'h3F);
      bus(1'b0, 8'h45, j[2], 8'h00);
      idle(8);
    end
    giveVerdict();
  end
endmodule

bind timer8_waveform_mode_control timer8_waveform_mode_control_checker chk (
  .clk(clk), .reset(reset), .ce(ce), .busAddr(busAddr), .ioSpace(ioSpace), .busWrite(busWrite),
  .busRead(busRead), .busWData(busWData), .busRData(busRData), .compareMatchA(compareMatchA),
  .compareMatchB(compareMatchB), .atTop(atTop), .atBottom(atBottom), .atMax(atMax), .dirOutA(dirOutA),
  .dirOutB(dirOutB), .portDataA(portDataA), .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOeB(pinOeB),
  .clockSelect(clockSelect), .waveGenMode(waveGenMode), .topIsCompareA(topIsCompareA),
  .dualSlope(dualSlope), .counterClear(counterClear), .compareFlagA(compareFlagA),
  .compareFlagB(compareFlagB), .compareUpdate(compareUpdate), .overflowFlag(overflowFlag),
  .waveOutA(waveOutA), .overrideA(overrideA)
);
